// >>> pkg/clock_gen_config_defs.svh
// constants of the clock generator configuration register group
// assumes byte-wide registers reached over the two-wire serial port
`ifndef CLOCK_GEN_CONFIG_DEFS_SVH
`define CLOCK_GEN_CONFIG_DEFS_SVH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define ADDR_PORT_CONFIG 16'h0000
`define ADDR_SILICON_REVISION 16'h0002
`define ADDR_PART_IDENTIFIER 16'h0003
`define ADDR_READBACK_SELECT 16'h0004
`define ADDR_USER_TAG_LOW 16'h0005
`define ADDR_USER_TAG_HIGH 16'h0006
`define ADDR_PLL_CONTROL_FIRST 16'h0010

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define SOFT_RESET_BIT 5
`define READBACK_ACTIVE_BIT 0
`define PHASE_DETECTOR_SENSE_BIT 7
`define PORT_CONFIG_RESET 8'h00
`define READBACK_SELECT_RESET 8'h00
`define USER_TAG_RESET 8'h00
// positive sense, largest pump current, normal pump mode, loop powered
`define PLL_CONTROL_RESET 8'h7C
// identity values are arbitrary
`define SILICON_REVISION_VALUE 8'h5A
`define PART_IDENTIFIER_VALUE 8'h3C
// serial port device address, arbitrary
`define SERIAL_DEVICE_ADDRESS 7'h2A
`define BUFFERED_COUNT 3

`endif

// >>> pkg/clock_gen_config_pkg.sv
// types shared by the configuration register group
// assumes the constants header is included by the design files
`default_nettype none
package clock_gen_config_pkg;

   // one register write from the serial engine
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [7:0] data;
   } reg_write_type;

   // serial engine states
   typedef enum logic [3:0] {
      st_idle,
      st_dev_addr,
      st_addr_high,
      st_addr_low,
      st_write_data,
      st_ack,
      st_read_data,
      st_read_ack,
      st_read_load
   } serial_state_type;

endpackage : clock_gen_config_pkg
`default_nettype wire

// >>> verilog/config_reg_store.sv
// buffered and active copies of the configuration registers
// assumes writes arrive as one-cycle strobes and the transfer input is a pulse
`timescale 1ns/1ns
`default_nettype none
`include "clock_gen_config_defs.svh"

module config_reg_store
   import clock_gen_config_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // control
   input wire reg_write_type i_write,
   input wire logic i_restore,
   input wire logic i_transfer_active,
   // readback
   input wire logic [15:0] i_read_addr,
   input wire logic i_read_active,
   output logic [7:0] o_read_data,
   output logic o_read_hit,
   // active copies
   output logic [7:0] o_user_tag_low,
   output logic [7:0] o_user_tag_high,
   output logic [7:0] o_pll_control
);

   // -----------------------------------------------------------------
   // decoding
   // -----------------------------------------------------------------
   // maps an address to its slot; index BUFFERED_COUNT means no hit
   function automatic logic [1:0] slot_of(input logic [15:0] addr);
      case (addr)
         `ADDR_USER_TAG_LOW: slot_of = 2'h0;
         `ADDR_USER_TAG_HIGH: slot_of = 2'h1;
         `ADDR_PLL_CONTROL_FIRST: slot_of = 2'h2;
         default: slot_of = 2'h3;
      endcase
   endfunction : slot_of

   function automatic logic [7:0] default_of(input int slot);
      default_of = (slot == 2) ? `PLL_CONTROL_RESET : `USER_TAG_RESET;
   endfunction : default_of

   logic [7:0] buffered [`BUFFERED_COUNT];
   logic [7:0] active [`BUFFERED_COUNT];
   logic [1:0] write_slot;
   logic [1:0] read_slot;

   assign write_slot = slot_of(i_write.addr);
   assign read_slot = slot_of(i_read_addr);

   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   // a write lands in the buffered copy; it reaches the loop on transfer
   for (genvar g = 0; g < `BUFFERED_COUNT; g++) begin : g_slot
      always_ff @(posedge i_clk_sys) begin
         if (!i_resetn || i_restore) begin
            buffered[g] <= default_of(g);
            active[g] <= default_of(g);
         end else begin
            if (i_write.valid && write_slot == 2'(g)) begin
               buffered[g] <= i_write.data;
            end
            if (i_transfer_active) begin
               active[g] <= buffered[g];
            end
         end
      end
   end

   // readback copy chosen by the select bit
   always_comb begin
      o_read_hit = (read_slot != 2'h3);
      o_read_data = 8'h00;
      if (o_read_hit) begin
         o_read_data = i_read_active ? active[read_slot] : buffered[read_slot];
      end
   end

   assign o_user_tag_low = active[0];
   assign o_user_tag_high = active[1];
   assign o_pll_control = active[2];

endmodule : config_reg_store
`default_nettype wire

// >>> verilog/clock_gen_config_regs.sv
// configuration register group with its two-wire serial port engine
// assumes scl and sda arrive synchronous to the system clock and sda is open drain
//
// Notes on behaviour
// - writing 1 to the soft reset bit restores defaults of all but 0x000, which keeps its written bits; clears on next scl cycle
// - revision byte at 0x002 is read only; writes are ignored
// - part identification byte at 0x003 is a fixed read-only code
// - bit 0 of 0x004 picks buffered (0) or active (1) copy for readback
// - 16-bit user version tag at 0x005/0x006, writable, default zero, no effect
// - bit 7 of 0x010 sets phase detector sense; 0 positive and default
`timescale 1ns/1ns
`default_nettype none
`include "clock_gen_config_defs.svh"

module clock_gen_config_regs
   import clock_gen_config_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // serial port pins
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   // copy buffered settings into the active set
   input wire logic i_transfer_active,
   // state of the block
   output logic [7:0] o_port_config,
   output logic o_soft_reset,
   output logic o_readback_active,
   output logic [15:0] o_user_version_tag,
   output logic [7:0] o_pll_control,
   output logic o_phase_detector_sense
);

   // -----------------------------------------------------------------
   // pin sampling
   // -----------------------------------------------------------------
   logic scl_q;
   logic sda_q;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // previous pin levels for edge and condition detection
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
      end
   end

   assign scl_rise = i_scl && !scl_q;
   assign scl_fall = !i_scl && scl_q;
   assign start_seen = i_scl && scl_q && sda_q && !i_sda;
   assign stop_seen = i_scl && scl_q && !sda_q && i_sda;

   // -----------------------------------------------------------------
   // registers local to this file
   // -----------------------------------------------------------------
   logic [7:0] port_config;
   logic [7:0] readback_select;
   logic soft_reset_armed;
   reg_write_type write_req;
   serial_state_type state;
   serial_state_type ack_next;
   logic [15:0] addr;
   logic [7:0] shift;
   logic [3:0] bit_count;
   logic [7:0] read_data;
   logic [7:0] store_data;
   logic store_hit;
   logic [7:0] tag_low;
   logic [7:0] tag_high;
   logic [7:0] pll_control;

   // port config: stored as written, mirror kept by the host
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         port_config <= `PORT_CONFIG_RESET;
         soft_reset_armed <= 1'b0;
      end else begin
         if (write_req.valid && write_req.addr == `ADDR_PORT_CONFIG) begin
            port_config <= write_req.data;
         end else if (soft_reset_armed && scl_rise) begin
            port_config[`SOFT_RESET_BIT] <= 1'b0;
         end
         // arm once the byte's acknowledge ends, clear on the next scl rise
         if (state == st_ack && scl_fall && port_config[`SOFT_RESET_BIT]) begin
            soft_reset_armed <= 1'b1;
         end else if (scl_rise) begin
            soft_reset_armed <= 1'b0;
         end
      end
   end

   // readback select; soft reset restores it like the other settings
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn || port_config[`SOFT_RESET_BIT]) begin
         readback_select <= `READBACK_SELECT_RESET;
      end else if (write_req.valid && write_req.addr == `ADDR_READBACK_SELECT) begin
         readback_select <= {7'h00, write_req.data[`READBACK_ACTIVE_BIT]};
      end
   end

   // -----------------------------------------------------------------
   // buffered and active settings
   // -----------------------------------------------------------------
   config_reg_store u_store (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_write(write_req),
      .i_restore(port_config[`SOFT_RESET_BIT]),
      .i_transfer_active(i_transfer_active),
      .i_read_addr(addr),
      .i_read_active(readback_select[`READBACK_ACTIVE_BIT]),
      .o_read_data(store_data),
      .o_read_hit(store_hit),
      .o_user_tag_low(tag_low),
      .o_user_tag_high(tag_high),
      .o_pll_control(pll_control)
   );

   // readback mux; identity bytes are constants, unmapped reads give zero
   always_comb begin
      case (addr)
         `ADDR_PORT_CONFIG: read_data = port_config;
         `ADDR_SILICON_REVISION: read_data = `SILICON_REVISION_VALUE;
         `ADDR_PART_IDENTIFIER: read_data = `PART_IDENTIFIER_VALUE;
         `ADDR_READBACK_SELECT: read_data = readback_select;
         default: read_data = store_hit ? store_data : 8'h00;
      endcase
   end

   // -----------------------------------------------------------------
   // serial engine
   // -----------------------------------------------------------------
   // bits are taken on scl rise and driven on scl fall, so sda never
   // moves while scl is high and cannot fake a start or stop
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         state <= st_idle;
         ack_next <= st_idle;
         addr <= 16'h0000;
         shift <= 8'h00;
         bit_count <= 4'h0;
         o_sda_oe_n <= 1'b1;
         write_req <= '0;
      end else begin
         write_req.valid <= 1'b0;
         if (start_seen) begin
            state <= st_dev_addr;
            bit_count <= 4'h0;
            o_sda_oe_n <= 1'b1;
         end else if (stop_seen) begin
            state <= st_idle;
            o_sda_oe_n <= 1'b1;
         end else begin
            case (state)
               st_dev_addr, st_addr_high, st_addr_low, st_write_data: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], i_sda};
                     bit_count <= bit_count + 4'h1;
                  end else if (scl_fall && bit_count == 4'h8) begin
                     bit_count <= 4'h0;
                     o_sda_oe_n <= 1'b0;
                     state <= st_ack;
                     case (state)
                        st_dev_addr: begin
                           // foreign address: let go of the bus until the next start
                           if (shift[7:1] != `SERIAL_DEVICE_ADDRESS) begin
                              o_sda_oe_n <= 1'b1;
                              state <= st_idle;
                           end
                           ack_next <= shift[0] ? st_read_data : st_addr_high;
                        end
                        st_addr_high: begin
                           addr[15:8] <= shift;
                           ack_next <= st_addr_low;
                        end
                        st_addr_low: begin
                           addr[7:0] <= shift;
                           ack_next <= st_write_data;
                        end
                        default: begin
                           // identity bytes take no write
                           write_req.valid <= (addr != `ADDR_SILICON_REVISION)
                              && (addr != `ADDR_PART_IDENTIFIER);
                           write_req.addr <= addr;
                           write_req.data <= shift;
                           // step here, not at the acknowledge, so address bytes never move it
                           addr <= addr + 16'h0001;
                           ack_next <= st_write_data;
                        end
                     endcase
                  end
               end
               st_ack: begin
                  if (scl_fall) begin
                     o_sda_oe_n <= 1'b1;
                     state <= ack_next;
                     if (ack_next == st_read_data) begin
                        shift <= read_data;
                        o_sda_oe_n <= read_data[7];
                     end
                  end
               end
               st_read_data: begin
                  if (scl_fall) begin
                     bit_count <= bit_count + 4'h1;
                     if (bit_count == 4'h7) begin
                        o_sda_oe_n <= 1'b1;
                        bit_count <= 4'h0;
                        state <= st_read_ack;
                     end else begin
                        shift <= {shift[6:0], 1'b0};
                        o_sda_oe_n <= shift[6];
                     end
                  end
               end
               st_read_ack: begin
                  // host ack continues the burst, nack ends it
                  if (scl_rise) begin
                     if (i_sda) begin
                        state <= st_idle;
                     end else begin
                        addr <= addr + 16'h0001;
                        state <= st_read_load;
                     end
                  end
               end
               st_read_load: begin
                  if (scl_fall) begin
                     shift <= read_data;
                     o_sda_oe_n <= read_data[7];
                     state <= st_read_data;
                  end
               end
               default: begin
                  o_sda_oe_n <= 1'b1;
               end
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   // sda only ever pulls low; the level comes from the enable
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_sda_out <= 1'b0;
      end else begin
         o_sda_out <= 1'b0;
      end
   end

   always_comb begin
      o_port_config = port_config;
      o_soft_reset = port_config[`SOFT_RESET_BIT];
      o_readback_active = readback_select[`READBACK_ACTIVE_BIT];
      o_user_version_tag = {tag_high, tag_low};
      o_pll_control = pll_control;
      o_phase_detector_sense = pll_control[`PHASE_DETECTOR_SENSE_BIT];
   end

endmodule : clock_gen_config_regs
`default_nettype wire

// >>> test/clock_gen_config_regs_sva.sv
// assertions on the ports of the configuration register group
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "clock_gen_config_defs.svh"

module clock_gen_config_regs_sva (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_resetn,
   // serial pins
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   // state
   input wire logic i_transfer_active,
   input wire logic [7:0] o_port_config,
   input wire logic o_soft_reset,
   input wire logic o_readback_active,
   input wire logic [15:0] o_user_version_tag,
   input wire logic [7:0] o_pll_control,
   input wire logic o_phase_detector_sense
);
   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_resetn);

   // a standing soft reset puts the sense back to positive
   AST_SENSE_BIT: assert property (o_soft_reset && $past(o_soft_reset) |->
      !o_phase_detector_sense)
      else $error("sense not positive during soft reset");
   // soft reset can only come from an acknowledged write
   AST_SOFT_BIT: assert property ($rose(o_soft_reset) |-> !$past(o_sda_oe_n))
      else $error("soft reset set outside a write");
   // first edge after release must show defaults
   AST_RESET_STATE: assert property ($rose(i_resetn) |-> o_pll_control == `PLL_CONTROL_RESET
      && o_user_version_tag == 16'h0000 && !o_readback_active && !o_soft_reset)
      else $error("defaults missing after reset");
   AST_SOFT_RESTORE: assert property (o_soft_reset && $past(o_soft_reset) |->
      o_user_version_tag == 16'h0000 && o_pll_control == `PLL_CONTROL_RESET
      && !o_readback_active)
      else $error("soft reset did not restore defaults");
   AST_SOFT_CLEAR: assert property ($rose(o_soft_reset) |-> ##[1:200] !o_soft_reset)
      else $error("soft reset bit did not clear itself");
   // active copies move only on a transfer pulse or a soft reset
   AST_TAG_CAUSE: assert property (!$stable(o_user_version_tag) |->
      $past(i_transfer_active) || o_soft_reset || $past(o_soft_reset))
      else $error("user tag changed without cause");
   AST_PLL_CAUSE: assert property (!$stable(o_pll_control) |->
      $past(i_transfer_active) || o_soft_reset || $past(o_soft_reset))
      else $error("pll control changed without cause");
   // the select bit moves only inside an acknowledged write or on a soft reset
   AST_SELECT_CAUSE: assert property (!$stable(o_readback_active) |->
      !$past(o_sda_oe_n) || o_soft_reset || $past(o_soft_reset))
      else $error("readback select changed without cause");
   // open drain: a driven wire is always low
   AST_DRIVE_LOW: assert property (!o_sda_oe_n |-> !o_sda_out)
      else $error("sda driven high");
endmodule : clock_gen_config_regs_sva
`default_nettype wire

// >>> test/host_model.sv
// serial bus host: start, stop, byte send and receive
// assumes sda has a pull-up resolved by the bench; pins change on falling clock edges
`timescale 1ns/1ns
`default_nettype none

module host_model (
   // clock
   input wire logic i_clk_sys,
   // bus
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda
);
   // ---------------------------------------------
   // bus phases
   // ---------------------------------------------
   // idle bus: clock stands high, data released
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // four system cycles keeps each phase above the one cycle the port needs
   task automatic ph();
      repeat (4) @(negedge i_clk_sys);
   endtask : ph
   task automatic start();
      o_sda = 1'b1;
      ph();
      o_scl = 1'b1;
      ph();
      o_sda = 1'b0;
      ph();
      o_scl = 1'b0;
      ph();
   endtask : start
   task automatic stop();
      o_sda = 1'b0;
      ph();
      o_scl = 1'b1;
      ph();
      o_sda = 1'b1;
      ph();
   endtask : stop
   // msb first; ack taken while the ninth clock is high
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         o_sda = b[i];
         ph();
         o_scl = 1'b1;
         ph();
         o_scl = 1'b0;
         ph();
      end
      o_sda = 1'b1;
      ph();
      o_scl = 1'b1;
      ph();
      ack = !i_sda;
      o_scl = 1'b0;
      ph();
   endtask : send
   task automatic recv(input logic last, output logic [7:0] b);
      o_sda = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         ph();
         o_scl = 1'b1;
         ph();
         b[i] = i_sda;
         o_scl = 1'b0;
      end
      ph();
      o_sda = last;
      ph();
      o_scl = 1'b1;
      ph();
      o_scl = 1'b0;
      ph();
      o_sda = 1'b1;
   endtask : recv
endmodule : host_model
`default_nettype wire

// >>> test/clock_gen_config_regs_tb.sv
// self-checking bench for the configuration register group
// assumes the host model drives the bus and sda is pulled up
`timescale 1ns/1ns
`default_nettype none
`include "clock_gen_config_defs.svh"

module clock_gen_config_regs_tb;
   logic i_clk_sys, i_resetn, i_transfer_active, scl, host_sda, o_sda_out, o_sda_oe_n;
   logic o_soft_reset, o_readback_active, o_phase_detector_sense, soft_seen;
   logic [7:0] o_port_config, o_pll_control;
   logic [15:0] o_user_version_tag, v;
   wire sda;
   int err_count = 0;
   int num_checks = 0;

   // wired and with pull-up
   assign sda = host_sda & (o_sda_oe_n | o_sda_out);
   clock_gen_config_regs i_clock_gen_config_regs (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
      .i_scl(scl), .i_sda(sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
      .i_transfer_active(i_transfer_active), .o_port_config(o_port_config),
      .o_soft_reset(o_soft_reset), .o_readback_active(o_readback_active),
      .o_user_version_tag(o_user_version_tag), .o_pll_control(o_pll_control),
      .o_phase_detector_sense(o_phase_detector_sense));
   host_model i_host_model (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda(host_sda));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask : chk
   task automatic adr(input logic [15:0] a, input logic rd_dir, output logic ok);
      logic k1, k2, k3;
      i_host_model.start();
      i_host_model.send({`SERIAL_DEVICE_ADDRESS, 1'b0}, k1);
      i_host_model.send(a[15:8], k2);
      i_host_model.send(a[7:0], k3);
      ok = k1 & k2 & k3;
   endtask : adr
   // bytes go out low byte first, address steps by one
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input int n);
      logic ok, k;
      adr(a, 1'b0, ok);
      for (int i = 0; i < n; i++) begin
         i_host_model.send(d[8*i+:8], k);
         ok &= k;
      end
      i_host_model.stop();
      chk({15'h0, ok}, 16'h0001);
   endtask : wr
   task automatic rd(input logic [15:0] a, input int n, output logic [15:0] r);
      logic ok, k;
      logic [7:0] b;
      r = 16'h0000;
      adr(a, 1'b0, ok);
      i_host_model.start();
      i_host_model.send({`SERIAL_DEVICE_ADDRESS, 1'b1}, k);
      for (int i = 0; i < n; i++) begin
         i_host_model.recv(i == n - 1, b);
         r[8*i+:8] = b;
      end
      i_host_model.stop();
      chk({15'h0, ok & k}, 16'h0001);
   endtask : rd
   task automatic pulse();
      i_transfer_active = 1'b1;
      @(negedge i_clk_sys);
      i_transfer_active = 1'b0;
      @(negedge i_clk_sys);
   endtask : pulse

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_ident();
      rd(16'h0002, 1, v);
      chk(v, {8'h00, `SILICON_REVISION_VALUE});
      rd(16'h0003, 1, v);
      chk(v, {8'h00, `PART_IDENTIFIER_VALUE});
      wr(16'h0002, 16'h0081, 1);
      rd(16'h0002, 1, v);
      chk(v, {8'h00, `SILICON_REVISION_VALUE});
      rd(16'h000F, 1, v);
      chk(v, 16'h0000);
   endtask : t_ident
   task automatic t_tag();
      wr(16'h0005, 16'hB7D4, 2);
      chk(o_user_version_tag, 16'h0000);
      rd(16'h0005, 2, v);
      chk(v, 16'hB7D4);
      pulse();
      chk(o_user_version_tag, 16'hB7D4);
   endtask : t_tag
   // negative sense, as with an external oscillator
   task automatic t_sense();
      wr(16'h0010, 16'h00FC, 1);
      chk({15'h0, o_phase_detector_sense}, 16'h0000);
      wr(16'h0004, 16'h0001, 1);
      chk({15'h0, o_readback_active}, 16'h0001);
      rd(16'h0010, 1, v);
      chk(v, {8'h00, `PLL_CONTROL_RESET});
      pulse();
      chk({15'h0, o_phase_detector_sense}, 16'h0001);
      rd(16'h0010, 1, v);
      chk(v, 16'h00FC);
   endtask : t_sense
   // mirrored nibble 0x24 sets soft reset with bit 2 as its image
   task automatic t_soft();
      wr(16'h0000, 16'h0024, 1);
      chk({15'h0, soft_seen}, 16'h0001);
      chk({8'h00, o_port_config}, 16'h0004);
      chk(o_user_version_tag, 16'h0000);
      chk({8'h00, o_pll_control}, {8'h00, `PLL_CONTROL_RESET});
      chk({15'h0, o_readback_active}, 16'h0000);
      rd(16'h0010, 1, v);
      chk(v, {8'h00, `PLL_CONTROL_RESET});
   endtask : t_soft
   task automatic t_nack();
      logic k;
      i_host_model.start();
      i_host_model.send({~`SERIAL_DEVICE_ADDRESS, 1'b0}, k);
      i_host_model.stop();
      chk({15'h0, k}, 16'h0000);
   endtask : t_nack

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // 4 ns clock
   initial begin
      i_clk_sys = 1'b0;
      forever #2 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      if (!i_resetn) soft_seen <= 1'b0;
      else if (o_soft_reset) soft_seen <= 1'b1;
   end
   // the run needs about 7100 cycles
   initial begin
      repeat (60000) @(posedge i_clk_sys);
      err_count++;
      tally_and_finish();
   end
   initial begin
      i_resetn = 1'b0;
      i_transfer_active = 1'b0;
      repeat (16) @(negedge i_clk_sys);
      i_resetn = 1'b1;
      @(negedge i_clk_sys);
      chk({8'h00, o_pll_control}, {8'h00, `PLL_CONTROL_RESET});
      chk({o_port_config, 7'h0, o_readback_active}, 16'h0000);
      chk(o_user_version_tag, 16'h0000);
      t_ident();
      t_tag();
      t_sense();
      t_soft();
      t_nack();
      tally_and_finish();
   end
endmodule : clock_gen_config_regs_tb

bind clock_gen_config_regs clock_gen_config_regs_sva i_clock_gen_config_regs_sva (
   .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda),
   .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .i_transfer_active(i_transfer_active),
   .o_port_config(o_port_config), .o_soft_reset(o_soft_reset),
   .o_readback_active(o_readback_active), .o_user_version_tag(o_user_version_tag),
   .o_pll_control(o_pll_control), .o_phase_detector_sense(o_phase_detector_sense));
`default_nettype wire
